// >>> hdl/wwt_pkg.sv
// Package of the windowed watchdog: register map, field positions, reset
// values and timing constants.
// Assumes a 32-bit APB bus and a 250 MHz system clock.
package wwt_pkg;

  // Register byte offsets
  localparam logic [7:0] MODE_OFS    = 8'h00;
  localparam logic [7:0] TIMEOUT_OFS = 8'h04;
  localparam logic [7:0] FEED_OFS    = 8'h08;
  localparam logic [7:0] COUNT_OFS   = 8'h0c;
  localparam logic [7:0] WARN_OFS    = 8'h10;
  localparam logic [7:0] WINDOW_OFS  = 8'h14;
  localparam logic [7:0] CLKSEL_OFS  = 8'h18;
  localparam logic [7:0] STATUS_OFS  = 8'h1c;
  localparam logic [7:0] CLEAR_OFS   = 8'h20;
  localparam logic [7:0] IRQEN_OFS   = 8'h24;
  localparam logic [7:0] RSTFLAG_OFS = 8'h28;

  // Field positions
  localparam int MODE_ENABLE_BIT = 0;
  localparam int MODE_RESET_BIT  = 1;
  localparam int EVT_TIMEOUT_BIT = 0;
  localparam int EVT_WARN_BIT    = 1;
  localparam int EVT_FEED_BIT    = 2;
  localparam int EVT_COUNT       = 3;

  // Feed keys and reset values
  localparam logic [7:0]  FEED_KEY_FIRST  = 8'haa;
  localparam logic [7:0]  FEED_KEY_SECOND = 8'h55;
  localparam logic [23:0] TIMEOUT_MIN     = 24'h0000ff;
  localparam logic [23:0] TIMEOUT_RST     = 24'h0000ff;
  localparam logic [23:0] WARN_RST        = 24'h000000;
  localparam logic [23:0] WINDOW_RST      = 24'hffffff;
  localparam logic [1:0]  PRESCALE_LAST   = 2'h3;

  // Timing: system clock period and nominal RC oscillator rate
  localparam int SYS_CLK_PERIOD_NS = 4;
  localparam int IRC_FREQ_MHZ      = 12;
  localparam int IRC_PERIOD_CYCLES = 1000 / (IRC_FREQ_MHZ * SYS_CLK_PERIOD_NS);

  // Mode register fields
  typedef struct packed {
    logic reset_en;
    logic enable;
  } wwt_mode_t;

  // Event set as carried between logic and status register
  typedef struct packed {
    logic feed_err;
    logic warn;
    logic timeout;
  } wwt_evt_t;

endpackage

// >>> hdl/wwt_top.sv
// Windowed watchdog timer with APB register access.
// Assumes both watchdog clock sources arrive as free-running pins slower than
// a third of SYS_CLK, and that NRST is the power-on reset of the block.
// Function
// - Counter expiring without a reload pulses the chip reset output, or interrupt when reset disabled.
// - In window mode a feed above the window value is an error.
// - Warning status bit sets when the counter passes the warning value.
// - Enable bit is set-only; cleared only by reset or watchdog event.
// - Broken feed sequence causes reset, or interrupt when reset disabled.
// - Sticky flag reports that the watchdog caused a chip reset.
// - Counter is 24 bits, decremented through a prescaler on tick clock.
// - Time-out spans 256 by 4 to 2^24 by 4 tick periods, steps of 4.
// - Tick clock chosen between internal RC and dedicated oscillator.
// - Internal RC oscillator runs nominally at 12 MHz.
// - In deep sleep the RC output is gated off unless it is selected.
`timescale 1ns/100ps
`default_nettype none

module wwt_top
  import wwt_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              SYS_CLK,
  input  wire logic              NRST,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output var  logic [31:0]       PRDATA,
  output var  logic              PREADY,
  output var  logic              PSLVERR,
  input  wire logic              INTERNAL_RC_OSCILLATOR,
  input  wire logic              DEDICATED_WATCHDOG_OSCILLATOR,
  input  wire logic              DEEP_SLEEP,
  output var  logic              RC_OUTPUT_EN,
  output var  logic              CHIP_RESET,
  output var  logic              IRQ
);

  // Reset release through two flip-flops
  logic       rst_meta;
  logic       rst_n;
  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Register state
  wwt_mode_t   mode;
  logic [23:0] timeout_val;
  logic [23:0] warn_val;
  logic [23:0] window_val;
  logic        clk_sel;
  wwt_evt_t    status;
  wwt_evt_t    irq_en;
  logic        wd_reset_flag;
  logic [23:0] count;
  logic [1:0]  prescale;
  logic        running;
  logic        feed_armed;

  // Bus decode; the slave never inserts wait states
  logic              acc;
  logic              wr;
  logic [ADDR_W-1:0] addr;
  logic              mapped;
  assign acc  = PSEL && PENABLE && PREADY;
  assign wr   = acc && PWRITE;
  assign addr = PADDR;

  always_comb begin
    case (addr[7:0])
      MODE_OFS, TIMEOUT_OFS, FEED_OFS, COUNT_OFS, WARN_OFS, WINDOW_OFS,
      CLKSEL_OFS, STATUS_OFS, CLEAR_OFS, IRQEN_OFS, RSTFLAG_OFS: begin
        mapped = (addr >> 8) == '0;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Oscillator pins: two-flop synchronisers plus one stage for edge detect
  logic [2:0] irc_sync;
  logic [2:0] wdo_sync;
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      irc_sync <= 3'h0;
      wdo_sync <= 3'h0;
    end else begin
      irc_sync <= {irc_sync[1:0], INTERNAL_RC_OSCILLATOR};
      wdo_sync <= {wdo_sync[1:0], DEDICATED_WATCHDOG_OSCILLATOR};
    end
  end

  // Tick on rising edge of the selected source
  logic tick;
  logic presc_wrap;
  assign tick = clk_sel ? (wdo_sync[1] && !wdo_sync[2])
                        : (irc_sync[1] && !irc_sync[2]);
  assign presc_wrap = tick && (prescale == PRESCALE_LAST);

  // Feed sequence tracking over bus accesses
  logic feed_wr;
  logic key1;
  logic key2;
  logic seq_err;
  logic feed_ok;
  logic window_err;
  assign feed_wr = wr && (addr[7:0] == FEED_OFS) && mapped;
  assign key1    = feed_wr && (PWDATA[7:0] == FEED_KEY_FIRST);
  assign key2    = feed_wr && (PWDATA[7:0] == FEED_KEY_SECOND);
  // Any access after the first key other than the second key breaks it
  assign seq_err = mode.enable && acc && (feed_armed ? !key2 : (feed_wr && !key1));
  assign feed_ok = mode.enable && feed_armed && key2;
  // Feeding while the count is still above the window is too early
  assign window_err = feed_ok && running && (count > window_val);

  // Events of this cycle
  wwt_evt_t evt;
  assign evt.timeout  = running && presc_wrap && (count == 24'h000000);
  assign evt.warn     = running && presc_wrap && (count == warn_val) && (count != 24'h000000);
  assign evt.feed_err = seq_err || window_err;

  logic fatal_evt;
  assign fatal_evt = evt.timeout || evt.feed_err;

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      feed_armed <= 1'b0;
    end else if (acc) begin
      feed_armed <= !feed_armed && key1 && mode.enable;
    end
  end

  // Mode: enable and reset selection can only be set by software
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      mode <= '0;
    end else if (fatal_evt) begin
      mode.enable <= 1'b0;
    end else if (wr && mapped && addr[7:0] == MODE_OFS) begin
      mode.enable   <= mode.enable || PWDATA[MODE_ENABLE_BIT];
      mode.reset_en <= mode.reset_en || PWDATA[MODE_RESET_BIT];
    end
  end

  // Time-out, warning, window and clock select registers
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      timeout_val <= TIMEOUT_RST;
      warn_val    <= WARN_RST;
      window_val  <= WINDOW_RST;
      clk_sel     <= 1'b0;
    end else if (wr && mapped) begin
      case (addr[7:0])
        TIMEOUT_OFS: begin
          // Values below the minimum are raised to it
          timeout_val <= (PWDATA[23:0] < TIMEOUT_MIN) ? TIMEOUT_MIN : PWDATA[23:0];
        end
        WARN_OFS: begin
          warn_val <= PWDATA[23:0];
        end
        WINDOW_OFS: begin
          window_val <= PWDATA[23:0];
        end
        CLKSEL_OFS: begin
          // Switching source while running may drop or add one tick
          clk_sel <= PWDATA[0];
        end
        default: begin
          timeout_val <= timeout_val;
        end
      endcase
    end
  end

  // Prescaler: divides the tick clock by four
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      prescale <= 2'h0;
    end else if (feed_ok && !window_err) begin
      prescale <= 2'h0;
    end else if (tick && running) begin
      prescale <= prescale + 2'h1;
    end
  end

  // Down counter: starts at first good feed, stops on any fatal event
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      count   <= TIMEOUT_RST;
      running <= 1'b0;
    end else if (fatal_evt) begin
      running <= 1'b0;
      count   <= timeout_val;
    end else if (feed_ok) begin
      running <= 1'b1;
      count   <= timeout_val;
    end else if (running && presc_wrap) begin
      count <= count - 24'h000001;
    end
  end

  // Sticky status: a new event wins over a clear in the same cycle
  logic [EVT_COUNT-1:0] clr_mask;
  assign clr_mask = (wr && mapped && addr[7:0] == CLEAR_OFS) ? PWDATA[EVT_COUNT-1:0] : '0;

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      status <= (status & ~clr_mask) | evt;
    end
  end

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      irq_en <= '0;
    end else if (wr && mapped && addr[7:0] == IRQEN_OFS) begin
      irq_en <= PWDATA[EVT_COUNT-1:0];
    end
  end

  // Interrupt level; fatal events reach it only when reset is not chosen
  wwt_evt_t irq_src;
  assign irq_src = status & irq_en;
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= irq_src.warn || (!mode.reset_en && (irq_src.timeout || irq_src.feed_err));
    end
  end

  // Chip reset pulse on a fatal event when reset mode is chosen
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      CHIP_RESET <= 1'b0;
    end else begin
      CHIP_RESET <= fatal_evt && mode.reset_en;
    end
  end

  // Watchdog reset flag; cleared by writing one, kept over the chip reset
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wd_reset_flag <= 1'b0;
    end else if (fatal_evt && mode.reset_en) begin
      wd_reset_flag <= 1'b1;
    end else if (wr && mapped && addr[7:0] == RSTFLAG_OFS && PWDATA[0]) begin
      wd_reset_flag <= 1'b0;
    end
  end

  // Deep sleep pin through two flip-flops; it comes from the power controller
  logic [1:0] sleep_sync;
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sleep_sync <= 2'h0;
    end else begin
      sleep_sync <= {sleep_sync[0], DEEP_SLEEP};
    end
  end

  // RC output gate for deep sleep
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      RC_OUTPUT_EN <= 1'b1;
    end else begin
      RC_OUTPUT_EN <= !sleep_sync[1] || !clk_sel;
    end
  end

  // Read mux
  logic [31:0] rd;
  always_comb begin
    rd = 32'h00000000;
    case (addr[7:0])
      MODE_OFS: begin
        rd = {30'h0, mode.reset_en, mode.enable};
      end
      TIMEOUT_OFS: begin
        rd = {8'h00, timeout_val};
      end
      COUNT_OFS: begin
        rd = {8'h00, count};
      end
      WARN_OFS: begin
        rd = {8'h00, warn_val};
      end
      WINDOW_OFS: begin
        rd = {8'h00, window_val};
      end
      CLKSEL_OFS: begin
        rd = {31'h0, clk_sel};
      end
      STATUS_OFS: begin
        rd = {29'h0, status};
      end
      IRQEN_OFS: begin
        rd = {29'h0, irq_en};
      end
      RSTFLAG_OFS: begin
        rd = {31'h0, wd_reset_flag};
      end
      default: begin
        rd = 32'h00000000;
      end
    endcase
  end

  // Ready: no wait states once out of reset
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= 1'b1;
    end
  end

  // Read data is set up during the setup phase and stands until the next one
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL && !PENABLE) begin
      PRDATA <= PWRITE ? 32'h00000000 : rd;
    end
  end

  // Slave error for unmapped addresses, set up with the read data
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      PSLVERR <= 1'b0;
    end else if (PSEL && !PENABLE) begin
      PSLVERR <= !mapped;
    end
  end

endmodule

`default_nettype wire

// >>> verification/wwt_asserts.sv
// Port checker of the windowed watchdog.
// Assumes it is bound to wwt_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module wwt_asserts
  import wwt_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              SYS_CLK,
  input wire logic              NRST,
  input wire logic              PSEL,
  input wire logic              PENABLE,
  input wire logic              PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0]       PWDATA,
  input wire logic [31:0]       PRDATA,
  input wire logic              PREADY,
  input wire logic              PSLVERR,
  input wire logic              INTERNAL_RC_OSCILLATOR,
  input wire logic              DEDICATED_WATCHDOG_OSCILLATOR,
  input wire logic              DEEP_SLEEP,
  input wire logic              RC_OUTPUT_EN,
  input wire logic              CHIP_RESET,
  input wire logic              IRQ
);
  // Read setup cycle; data is due in the access cycle
  logic rd_s;
  assign rd_s = PSEL && !PENABLE && !PWRITE;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  a_rc_gate: assert property (!RC_OUTPUT_EN |-> $past(DEEP_SLEEP, 3)) else $error("rc gated awake");
  a_reset_pulse: assert property (CHIP_RESET |=> !CHIP_RESET) else $error("reset pulse long");
  a_unmapped_err: assert property (PSEL && !PENABLE && PADDR > RSTFLAG_OFS |=> PSLVERR) else $error("no slave error");
  a_mode_width: assert property (rd_s && PADDR == MODE_OFS |=> PRDATA[31:2] == '0) else $error("mode width");
  a_window_width: assert property (rd_s && PADDR == WINDOW_OFS |=> PRDATA[31:24] == '0) else $error("window width");
  a_warn_width: assert property (rd_s && PADDR == WARN_OFS |=> PRDATA[31:24] == '0) else $error("warn width");
  a_status_width: assert property (rd_s && PADDR == STATUS_OFS |=> PRDATA[31:3] == '0) else $error("status width");
  a_flag_width: assert property (rd_s && PADDR == RSTFLAG_OFS |=> PRDATA[31:1] == '0) else $error("flag width");
  a_count_width: assert property (rd_s && PADDR == COUNT_OFS |=> PRDATA[31:24] == '0) else $error("count width");
  a_timeout_floor: assert property (rd_s && PADDR == TIMEOUT_OFS |=> PRDATA[23:0] >= TIMEOUT_MIN) else $error("timeout low");
  a_clksel_width: assert property (rd_s && PADDR == CLKSEL_OFS |=> PRDATA[31:1] == '0) else $error("clksel width");
endmodule
bind wwt_top wwt_asserts #(.ADDR_W(ADDR_W)) u_wwt_asserts (.SYS_CLK(SYS_CLK), .NRST(NRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .INTERNAL_RC_OSCILLATOR(INTERNAL_RC_OSCILLATOR), .DEEP_SLEEP(DEEP_SLEEP),
  .DEDICATED_WATCHDOG_OSCILLATOR(DEDICATED_WATCHDOG_OSCILLATOR), .RC_OUTPUT_EN(RC_OUTPUT_EN),
  .CHIP_RESET(CHIP_RESET), .IRQ(IRQ));
`default_nettype wire

// >>> verification/wwt_tb_top.sv
// Self-checking bench of the windowed watchdog.
// Assumes wwt_top with its default address width.
`timescale 1ns/100ps
`default_nettype none
module windowed_watchdog_timer_tb_top;
  import wwt_pkg::*;
  logic        SYS_CLK, NRST, PSEL, PENABLE, PWRITE, DEEP_SLEEP, rc_osc, ded_osc;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, q;
  logic        PREADY, PSLVERR, RC_OUTPUT_EN, CHIP_RESET, IRQ, err_q;
  int          err_count, checked, cyc, t0, n;
  wwt_top u_wwt_top (.SYS_CLK(SYS_CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .INTERNAL_RC_OSCILLATOR(rc_osc), .DEDICATED_WATCHDOG_OSCILLATOR(ded_osc), .DEEP_SLEEP(DEEP_SLEEP),
    .RC_OUTPUT_EN(RC_OUTPUT_EN), .CHIP_RESET(CHIP_RESET), .IRQ(IRQ));
  // Oscillators well below a third of the system clock; rc rises every 6 cycles
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc % 3 == 2) rc_osc <= ~rc_osc;
    if (cyc % 5 == 4) ded_osc <= ~ded_osc;
  end
  task automatic test_done();
    $display("checked %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic fail(input string m);
    $display("ERROR %0t %s", $time, m);
    err_count++;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checked++;
    if (g !== e) fail(m);
  endtask
  // One APB transfer, then an idle cycle so the next one starts cleanly
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    k = 0;
    do begin @(posedge SYS_CLK); k++; end while (PREADY !== 1'b1 && k < 50);
    if (k >= 50) begin fail("no ready"); test_done(); end
    q = PRDATA; err_q = PSLVERR;
    PSEL <= 1'b0; PENABLE <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e, "read value");
  endtask
  // Bounded wait for the reset pulse or the interrupt
  task automatic wait_ev(input bit rst);
    n = 0;
    while ((rst ? CHIP_RESET : IRQ) !== 1'b1 && n < 20000) begin @(posedge SYS_CLK); n++; end
    if (n >= 20000) begin fail("event timeout"); test_done(); end
  endtask
  task automatic t_regs();
    rdc(MODE_OFS, 32'h0); rdc(WARN_OFS, 32'h0); rdc(STATUS_OFS, 32'h0); rdc(RSTFLAG_OFS, 32'h0);
    rdc(WINDOW_OFS, 32'h00ffffff); rdc(CLKSEL_OFS, 32'h0); rdc(TIMEOUT_OFS, 32'h000000ff);
    xfer(1'b0, 8'h40, 32'h0);
    chk({q[30:0], err_q}, 32'h1, "unmapped");
    xfer(1'b1, TIMEOUT_OFS, 32'h10); rdc(TIMEOUT_OFS, 32'h000000ff);
    xfer(1'b1, TIMEOUT_OFS, 32'h12345678); rdc(TIMEOUT_OFS, 32'h00345678);
    xfer(1'b1, TIMEOUT_OFS, 32'hff);
    $display("t_regs done");
  endtask
  task automatic t_feed_err();
    xfer(1'b1, IRQEN_OFS, 32'h4); xfer(1'b1, MODE_OFS, 32'h1); xfer(1'b1, MODE_OFS, 32'h0);
    rdc(MODE_OFS, 32'h1);
    xfer(1'b1, FEED_OFS, 32'haa); xfer(1'b0, COUNT_OFS, 32'h0); wait_ev(1'b0);
    rdc(STATUS_OFS, 32'h4); rdc(MODE_OFS, 32'h0);
    xfer(1'b1, CLEAR_OFS, 32'h4); rdc(STATUS_OFS, 32'h0);
    chk({31'h0, IRQ}, 32'h0, "irq stuck");
    $display("t_feed_err done");
  endtask
  task automatic t_window();
    xfer(1'b1, WINDOW_OFS, 32'h10); xfer(1'b1, MODE_OFS, 32'h1);
    xfer(1'b1, FEED_OFS, 32'haa); xfer(1'b1, FEED_OFS, 32'h55); rdc(STATUS_OFS, 32'h0);
    xfer(1'b1, FEED_OFS, 32'haa); xfer(1'b1, FEED_OFS, 32'h55); wait_ev(1'b0);
    rdc(STATUS_OFS, 32'h4);
    xfer(1'b1, CLEAR_OFS, 32'h4); xfer(1'b1, WINDOW_OFS, 32'hffffff);
    $display("t_window done");
  endtask
  task automatic t_sleep();
    DEEP_SLEEP <= 1'b1;
    xfer(1'b1, CLKSEL_OFS, 32'h1); repeat (3) @(posedge SYS_CLK);
    chk({31'h0, RC_OUTPUT_EN}, 32'h0, "rc not gated");
    xfer(1'b1, CLKSEL_OFS, 32'h0); repeat (3) @(posedge SYS_CLK);
    chk({31'h0, RC_OUTPUT_EN}, 32'h1, "rc gated");
    DEEP_SLEEP <= 1'b0;
    $display("t_sleep done");
  endtask
  // Warn after 128 x 4 ticks, reset after 256 x 4 ticks, 6 cycles a tick
  task automatic t_timeout();
    xfer(1'b1, WARN_OFS, 32'h80); xfer(1'b1, IRQEN_OFS, 32'h2); xfer(1'b1, MODE_OFS, 32'h3);
    xfer(1'b1, FEED_OFS, 32'haa); xfer(1'b1, FEED_OFS, 32'h55);
    t0 = cyc;
    wait_ev(1'b0);
    chk({31'h0, (cyc - t0 > 3040) && (cyc - t0 < 3104)}, 32'h1, "warn time");
    rdc(STATUS_OFS, 32'h2); xfer(1'b1, CLEAR_OFS, 32'h2);
    wait_ev(1'b1);
    chk({31'h0, (cyc - t0 > 6110) && (cyc - t0 < 6180)}, 32'h1, "timeout time");
    rdc(RSTFLAG_OFS, 32'h1); rdc(MODE_OFS, 32'h2);
    xfer(1'b1, RSTFLAG_OFS, 32'h1); rdc(RSTFLAG_OFS, 32'h0);
    $display("t_timeout done");
  endtask
  // Clock
  initial begin
    SYS_CLK = 1'b0;
    forever #2 SYS_CLK = ~SYS_CLK;
  end
  // Main sequence
  initial begin
    NRST = 1'b0; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0; PADDR = 8'h0; PWDATA = 32'h0;
    DEEP_SLEEP = 1'b0; rc_osc = 1'b0; ded_osc = 1'b0; cyc = 0; err_count = 0; checked = 0;
    repeat (6) @(posedge SYS_CLK);
    NRST <= 1'b1;
    n = 0;
    do begin @(posedge SYS_CLK); n++; end while (PREADY !== 1'b1 && n < 20);
    t_regs(); t_feed_err(); t_window(); t_sleep(); t_timeout();
    test_done();
  end
endmodule
`default_nettype wire
